//--- tb/vpi_core_model.sv
// core model: accepts each offer after a chosen delay, records vectors
// assumes the unit drops its offer the cycle after an accept
`timescale 1ns/100ps
module vpi_core_model (
  input wire clk_in, // system clock
  input wire rst_n_in, // sync reset, active low
  input wire [2:0] delay_in, // cycles to stall before accepting
  input wire irq_req_in, // offer from the unit
  input wire load_pc_in, // load pulse
  input wire [15:0] load_vector_in, // vector to load
  output reg ack_out, // accept pulse
  output reg [15:0] pc_out, // counter after last load
  output reg [31:0] loads_out // loads seen
);
  reg [2:0] wait_reg;
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      ack_out <= 1'b0;
      wait_reg <= 3'h0;
      pc_out <= 16'h0000;
      loads_out <= 32'h0;
    end
    else
    begin
      ack_out <= 1'b0;
      if (irq_req_in && !ack_out)
      begin
        if (wait_reg >= delay_in)
        begin
          ack_out <= 1'b1;
          wait_reg <= 3'h0;
        end
        else
          wait_reg <= wait_reg + 3'h1;
      end
      if (load_pc_in)
      begin
        pc_out <= load_vector_in;
        loads_out <= loads_out + 32'h1;
      end
    end
  end
endmodule

//--- tb/vpi_unit_sva.sv
// checker for the interrupt unit's core-side handshake and pulses
// assumes it is bound to vpi_unit and sees only its ports
`timescale 1ns/100ps
module vpi_unit_sva (
  input wire ref_clk_in, // system clock
  input wire reset_n_in, // sync reset, active low
  input wire int_ack_in, // core accepts offer
  input wire irq_req_out, // grant offered
  input wire [4:0] irq_priority_out, // offered priority
  input wire [15:0] irq_vector_out, // offered vector
  input wire push_state_out, // push pulse
  input wire load_pc_out, // load pulse
  input wire [15:0] load_vector_out, // loaded vector
  input wire [6:0] timer_unf_in, // timer underflows
  input wire stop_instruction_in, // oscillator wait
  input wire break_instruction_in, // break pulse
  input wire stop_wait_done_out // wait over pulse
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // ----------------------------------------
  // acceptance steps
  // ----------------------------------------
  sequence s_take;
    irq_req_out && int_ack_in;
  endsequence
  sequence s_serve;
    push_state_out ##1 load_pc_out;
  endsequence
  AST_PUSH: assert property (s_take |=> push_state_out)
    else $error("no push after accept");
  AST_DROP: assert property (s_take |=> !irq_req_out)
    else $error("offer stands after accept");
  AST_SERVE: assert property (s_take |=> s_serve)
    else $error("load does not follow push");
  AST_LOADVEC: assert property (s_take |-> ##2
    load_vector_out == $past(irq_vector_out, 2))
    else $error("loaded vector differs from offer");
  // every vector pair sits two bytes below the one of next higher priority
  AST_VEC: assert property (irq_req_out |->
    irq_priority_out inside {[1:17]} &&
    irq_vector_out == 16'hFFFE - {10'h000, irq_priority_out, 1'b0})
    else $error("vector does not match priority");
  AST_STOP: assert property (
    timer_unf_in[2] && stop_instruction_in |=> stop_wait_done_out)
    else $error("stop wait not ended");
  AST_STOPCAUSE: assert property (stop_wait_done_out |->
    $past(timer_unf_in[2] && stop_instruction_in))
    else $error("stop wait ended without cause");
  AST_RSTOFFER: assert property ($rose(reset_n_in) |->
    ##[1:3] irq_req_out && irq_priority_out == 5'h01)
    else $error("reset not offered first");
  AST_BRK: assert property (break_instruction_in |->
    ##[1:8] irq_req_out)
    else $error("break not offered");
endmodule

//--- tb/vpi_unit_tb.sv
// bench for vpi_unit: axi4-lite master, source pulses, core model
// assumes vpi_core_model and vpi_unit_sva are compiled before it
`timescale 1ns/100ps
module vpi_unit_tb;
  reg ref_clk_in, reset_n_in;
  reg [3:0] s_axi_awaddr_in = 4'h0, s_axi_araddr_in = 4'h0;
  reg [31:0] s_axi_wdata_in = 32'h0;
  reg s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
  reg s_axi_arvalid_in = 0, s_axi_rready_in = 0, alt = 0, stop = 0;
  reg [20:0] ev = 21'h0;
  reg [2:0] dly = 3'h0;
  wire [3:0] s_axi_wstrb_in = 4'hF;
  wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  wire s_axi_arready_out, s_axi_rvalid_out, int_ack_in, irq_req_out;
  wire push_state_out, load_pc_out, stop_wait_done_out;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
  wire [31:0] s_axi_rdata_out, loads;
  wire [4:0] irq_priority_out;
  wire [15:0] irq_vector_out, load_vector_out, pc;
  // one pulse bit per source; blanking idles high, falling is its event
  wire ext_irq_pin_zero_in = ev[0];
  wire ext_irq_pin_one_in = ev[1];
  wire ext_irq_pin_two_in = ev[2];
  wire remote_ovf_in = ev[3];
  wire sio1_done_in = ev[4];
  wire sio1_auto_done_in = ev[5];
  wire [6:0] timer_unf_in = ev[12:6];
  wire sio2_rx_done_in = ev[13];
  wire ext_irq_pin_three_in = ev[14];
  wire sio2_tx_done_in = ev[15];
  wire ext_irq_pin_four_in = ev[16];
  wire adc_done_in = ev[17];
  wire vacuum_display_blank_in = !ev[18];
  wire vacuum_display_digit_in = ev[19];
  wire break_instruction_in = ev[20];
  wire interval_active_in = alt;
  wire sio1_auto_mode_in = alt;
  wire stop_instruction_in = stop;
  integer num_errors = 0, checks_done = 0, a, i, exp_rd;
  reg [31:0] lfsr = 32'h1AB75F4E;
  reg [15:0] exp_q[$];
  vpi_unit u_vpi_unit (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wdata_in(s_axi_wdata_in),
    .s_axi_wstrb_in(s_axi_wstrb_in), .s_axi_wvalid_in(s_axi_wvalid_in),
    .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in),
    .ext_irq_pin_zero_in(ext_irq_pin_zero_in),
    .ext_irq_pin_one_in(ext_irq_pin_one_in),
    .ext_irq_pin_two_in(ext_irq_pin_two_in),
    .ext_irq_pin_three_in(ext_irq_pin_three_in),
    .ext_irq_pin_four_in(ext_irq_pin_four_in),
    .remote_ovf_in(remote_ovf_in), .interval_active_in(interval_active_in),
    .sio1_done_in(sio1_done_in), .sio1_auto_done_in(sio1_auto_done_in),
    .sio1_auto_mode_in(sio1_auto_mode_in), .timer_unf_in(timer_unf_in),
    .sio2_rx_done_in(sio2_rx_done_in), .sio2_tx_done_in(sio2_tx_done_in),
    .adc_done_in(adc_done_in),
    .vacuum_display_blank_in(vacuum_display_blank_in),
    .vacuum_display_digit_in(vacuum_display_digit_in),
    .break_instruction_in(break_instruction_in),
    .stop_instruction_in(stop_instruction_in), .int_ack_in(int_ack_in),
    .irq_req_out(irq_req_out), .irq_priority_out(irq_priority_out),
    .irq_vector_out(irq_vector_out), .push_state_out(push_state_out),
    .load_pc_out(load_pc_out), .load_vector_out(load_vector_out),
    .stop_wait_done_out(stop_wait_done_out));
  vpi_core_model u_vpi_core_model (.clk_in(ref_clk_in),
    .rst_n_in(reset_n_in), .delay_in(dly), .irq_req_in(irq_req_out),
    .load_pc_in(load_pc_out), .load_vector_in(load_vector_out),
    .ack_out(int_ack_in), .pc_out(pc), .loads_out(loads));
  initial
  begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function integer evb(input integer s, input integer sel);
    case (s)
      2: evb = sel ? 3 : 2;
      3: evb = sel ? 5 : 4;
      11: evb = 13;
      12: evb = sel ? 15 : 14;
      13: evb = sel ? 17 : 16;
      14: evb = sel ? 19 : 18;
      default: evb = s < 2 ? s : s + 2;
    endcase
  endfunction
  task chk(input [33:0] got, input [33:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task axi_wr(input [3:0] ad, input [31:0] d);
    integer n;
    begin
      @(posedge ref_clk_in);
      s_axi_awaddr_in <= ad;
      s_axi_wdata_in <= d;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      n = 0;
      while (!(s_axi_bvalid_out && s_axi_bready_in) && n < 99)
      begin
        @(posedge ref_clk_in);
        if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
        if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        n = n + 1;
      end
      s_axi_bready_in <= 1'b0;
      chk(s_axi_bresp_out, 0);
    end
  endtask
  task axi_rd(input [3:0] ad, input [31:0] m, input [31:0] e);
    integer n;
    begin
      @(posedge ref_clk_in);
      s_axi_araddr_in <= ad;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
      n = 0;
      while (!(s_axi_rvalid_out && s_axi_rready_in) && n < 99)
      begin
        @(posedge ref_clk_in);
        if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        n = n + 1;
      end
      s_axi_rready_in <= 1'b0;
      chk({s_axi_rresp_out, s_axi_rdata_out & m}, {2'h0, e});
    end
  endtask
  task kick(input [20:0] m);
    begin
      @(posedge ref_clk_in);
      ev <= m;
      @(posedge ref_clk_in);
      ev <= 21'h0;
    end
  endtask
  // waits for the core model's next load and compares the vector
  task serve;
    integer n, c;
    begin
      c = loads;
      n = 0;
      while (loads == c && n < 99)
      begin
        @(posedge ref_clk_in);
        n = n + 1;
      end
      chk(pc, exp_q.pop_front());
    end
  endtask
  task finish_test;
    begin
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial
  begin
    #200000;
    num_errors = num_errors + 1;
    $display("mismatch at %0t: run too long", $time);
    finish_test;
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    reset_n_in = 1'b0;
    repeat (3) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    exp_q.push_back(16'hFFFC);
    serve;
    axi_rd(4'h8, 32'h1, 32'h1);
    axi_wr(4'h4, lfsr);
    axi_rd(4'h4, 32'h7FFF, lfsr & 32'h7FFF);
    axi_wr(4'h4, 32'h0);
    axi_rd(4'h4, 32'h7FFF, 32'h0);
    axi_wr(4'h0, 32'hFFFF);
    axi_rd(4'h0, 32'hFFFF, 32'h0);
    kick(21'h40);
    axi_rd(4'h0, 32'hFFFF, 32'h10);
    axi_rd(4'hC, 32'h1, 32'h0);
    axi_wr(4'h0, 32'hFFEF);
    axi_rd(4'h0, 32'hFFFF, 32'h0);
    kick(21'h100000);
    exp_q.push_back(16'hFFDC);
    serve;
    for (a = 0; a < 2; a = a + 1)
      for (i = 0; i < 15; i = i + 1)
      begin
        alt <= a[0];
        stop <= a[0];
        dly <= lfsr[2:0];
        lfsr = nxt(lfsr);
        // selection changes may raise a stray request, so clear after
        axi_wr(4'h8, a ? 32'h3C1 : 32'h1);
        axi_wr(4'h0, 32'h0);
        kick(21'h1 << evb(i, !a));
        exp_rd = evb(i, !a) == evb(i, a) ? 1 << i : 0;
        axi_rd(4'h0, 32'h7FFF, exp_rd);
        axi_wr(4'h0, 32'h0);
        axi_wr(4'h4, 32'h1 << i);
        axi_wr(4'h8, a ? 32'h3C0 : 32'h0);
        kick(21'h1 << evb(i, a));
        exp_q.push_back(16'(32'hFFFA - 2 * i));
        serve;
        axi_rd(4'h8, 32'h1, 32'h1);
        axi_rd(4'h0, 32'h7FFF, 32'h0);
      end
    // break and three timers at once while masked
    axi_wr(4'h8, 32'h1);
    axi_wr(4'h0, 32'h0);
    axi_wr(4'h4, 32'h7FFF);
    kick(21'h101240);
    exp_q.push_back(16'hFFDC);
    serve;
    for (i = 4; i < 11; i = i + 3)
    begin
      axi_wr(4'h8, 32'h0);
      exp_q.push_back(16'(32'hFFFA - 2 * i));
      serve;
    end
    // pin one on its falling edge; flipping the polarity of a low pin
    // looks like an edge, and a rising edge must not count afterwards
    axi_wr(4'h8, 32'h5);
    axi_rd(4'h0, 32'h7FFF, 32'h2);
    axi_wr(4'h0, 32'h0);
    @(posedge ref_clk_in) ev <= 21'h2;
    axi_rd(4'h0, 32'h7FFF, 32'h0);
    @(posedge ref_clk_in) ev <= 21'h0;
    axi_rd(4'h0, 32'h7FFF, 32'h2);
    axi_wr(4'h4, 32'h2);
    axi_wr(4'h8, 32'h4);
    exp_q.push_back(16'hFFF8);
    serve;
    finish_test;
  end
endmodule
bind vpi_unit vpi_unit_sva u_sva (.ref_clk_in(ref_clk_in),
  .reset_n_in(reset_n_in), .int_ack_in(int_ack_in),
  .irq_req_out(irq_req_out), .irq_priority_out(irq_priority_out),
  .irq_vector_out(irq_vector_out), .push_state_out(push_state_out),
  .load_pc_out(load_pc_out), .load_vector_out(load_vector_out),
  .timer_unf_in(timer_unf_in), .stop_instruction_in(stop_instruction_in),
  .break_instruction_in(break_instruction_in),
  .stop_wait_done_out(stop_wait_done_out));

//--- verilog/vpi_consts.vh
// constants for the vectored priority interrupt unit
// assumes a 32-bit axi4-lite register bus and one 200 MHz clock
`ifndef VPI_CONSTS_VH
`define VPI_CONSTS_VH

// register byte offsets
`define VPI_OFS_REQ 4'h0
`define VPI_OFS_ENA 4'h4
`define VPI_OFS_CTRL 4'h8
`define VPI_OFS_STAT 4'hC

// control register fields
`define VPI_CTRL_IDIS 0
`define VPI_CTRL_POL_LO 1
`define VPI_CTRL_SEL_LO 6

// reset values
`define VPI_REQ_RST 15'h0000
`define VPI_ENA_RST 15'h0000
`define VPI_POL_RST 5'h00
`define VPI_SEL_RST 4'h0
`define VPI_IDIS_RST 1'b1

// vector low addresses; the high byte sits one above
`define VPI_VEC_RESET 16'hFFFC
`define VPI_VEC_FIRST 16'hFFFA
`define VPI_VEC_BREAK 16'hFFDC

// priority numbers
`define VPI_PRI_RESET 5'h01
`define VPI_PRI_FIRST 5'h02
`define VPI_PRI_BREAK 5'h11

// grant kinds
`define VPI_GK_NONE 2'h0
`define VPI_GK_RESET 2'h1
`define VPI_GK_MASK 2'h2
`define VPI_GK_BREAK 2'h3

// axi responses
`define VPI_RESP_OKAY 2'h0
`define VPI_RESP_SLVERR 2'h2

`endif

//--- verilog/vpi_unit.v
// vectored fixed-priority interrupt unit with axi4-lite registers
// assumes source events are one-cycle pulses synchronous to ref_clk_in,
// pin and display lines are levels, and the core acks one grant at a time
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
`include "vpi_consts.vh"

module vpi_unit #(
  parameter NSLOT = 15 // maskable vector slots, priorities 2 to 16
)(
  input wire ref_clk_in, // 200 MHz system clock
  input wire reset_n_in, // synchronous reset, active low
  // axi4-lite slave
  input wire [3:0] s_axi_awaddr_in, // write address
  input wire s_axi_awvalid_in, // write address valid
  output reg s_axi_awready_out, // write address ready
  input wire [31:0] s_axi_wdata_in, // write data
  input wire [3:0] s_axi_wstrb_in, // write strobes
  input wire s_axi_wvalid_in, // write data valid
  output reg s_axi_wready_out, // write data ready
  output reg [1:0] s_axi_bresp_out, // write response
  output reg s_axi_bvalid_out, // write response valid
  input wire s_axi_bready_in, // write response ready
  input wire [3:0] s_axi_araddr_in, // read address
  input wire s_axi_arvalid_in, // read address valid
  output reg s_axi_arready_out, // read address ready
  output reg [31:0] s_axi_rdata_out, // read data
  output reg [1:0] s_axi_rresp_out, // read response
  output reg s_axi_rvalid_out, // read data valid
  input wire s_axi_rready_in, // read data ready
  // sources
  input wire ext_irq_pin_zero_in, // external pin 0 level
  input wire ext_irq_pin_one_in, // external pin 1 level
  input wire ext_irq_pin_two_in, // external pin 2 level
  input wire ext_irq_pin_three_in, // external pin 3 level
  input wire ext_irq_pin_four_in, // external pin 4 level
  input wire remote_ovf_in, // remote-control counter overflow pulse
  input wire interval_active_in, // interval determination running
  input wire sio1_done_in, // serial 1 ordinary transfer done pulse
  input wire sio1_auto_done_in, // serial 1 last auto transfer pulse
  input wire sio1_auto_mode_in, // serial 1 automatic mode selected
  input wire [6:0] timer_unf_in, // bit0 16-bit timer, bits 6:1 timers 1-6
  input wire sio2_rx_done_in, // serial 2 receive done pulse
  input wire sio2_tx_done_in, // serial 2 transmit done pulse
  input wire adc_done_in, // conversion done pulse
  input wire vacuum_display_blank_in, // last timing before blanking
  input wire vacuum_display_digit_in, // digit timing level
  input wire break_instruction_in, // break executed pulse
  input wire stop_instruction_in, // core waits for oscillator
  // core side
  input wire int_ack_in, // core accepts the offered grant
  output reg irq_req_out, // a grant is offered
  output reg [4:0] irq_priority_out, // priority of offered grant
  output reg [15:0] irq_vector_out, // vector low address of grant
  output reg push_state_out, // pulse: push counter and status
  output reg load_pc_out, // pulse: load counter from vector
  output reg [15:0] load_vector_out, // vector for load_pc_out
  output reg stop_wait_done_out // pulse: stop oscillator wait over
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg [NSLOT-1:0] req_reg;
  reg [NSLOT-1:0] ena_reg;
  reg [4:0] pol_reg;
  reg [3:0] sel_reg;
  reg idis_reg;
  reg break_pend_reg;
  reg reset_pend_reg;
  reg [4:0] pin_prev_reg;
  reg blank_prev_reg;
  reg digit_prev_reg;
  reg [1:0] gkind_reg;
  reg [3:0] gidx_reg;
  reg [3:0] aw_addr_reg;
  reg aw_have_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg w_have_reg;

  // ------------------------------------------------------------
  // source events
  // ------------------------------------------------------------
  wire [4:0] pin_now;
  wire [4:0] pin_eff;
  wire [4:0] pin_edge;
  wire blank_fall;
  wire digit_rise;
  wire [NSLOT-1:0] src_set;

  assign pin_now = {ext_irq_pin_four_in, ext_irq_pin_three_in,
                    ext_irq_pin_two_in, ext_irq_pin_one_in,
                    ext_irq_pin_zero_in};
  // polarity 1 selects falling; a polarity change flips the effective
  // level and can look like an edge, which is why software re-clears
  assign pin_eff = pin_now ^ pol_reg;
  assign pin_edge = pin_eff & ~pin_prev_reg;
  assign blank_fall = ~vacuum_display_blank_in & blank_prev_reg;
  assign digit_rise = vacuum_display_digit_in & ~digit_prev_reg;

  assign src_set[0] = pin_edge[0];
  assign src_set[1] = pin_edge[1];
  assign src_set[2] = sel_reg[0] ? (remote_ovf_in & interval_active_in)
                      : pin_edge[2];
  assign src_set[3] = sio1_auto_mode_in ? sio1_auto_done_in
                      : sio1_done_in;
  assign src_set[10:4] = timer_unf_in;
  assign src_set[11] = sio2_rx_done_in;
  assign src_set[12] = sel_reg[1] ? sio2_tx_done_in
                       : pin_edge[3];
  assign src_set[13] = sel_reg[2] ? adc_done_in
                       : pin_edge[4];
  assign src_set[14] = sel_reg[3] ? digit_rise
                       : blank_fall;

  // ------------------------------------------------------------
  // arbitration
  // ------------------------------------------------------------
  wire [NSLOT-1:0] qual;
  reg [3:0] win_idx;
  reg win_any;
  reg [1:0] gkind_next;
  integer k;

  assign qual = req_reg & ena_reg & {NSLOT{~idis_reg}};

  always @*
  begin
    win_idx = 4'h0;
    win_any = 1'b0;
    // scan from lowest priority so the highest one lands last
    for (k = NSLOT - 1; k >= 0; k = k - 1)
    begin
      if (qual[k])
      begin
        win_idx = k[3:0];
        win_any = 1'b1;
      end
    end
    if (reset_pend_reg)
      gkind_next = `VPI_GK_RESET;
    else if (win_any)
      gkind_next = `VPI_GK_MASK;
    else if (break_pend_reg)
      gkind_next = `VPI_GK_BREAK;
    else
      gkind_next = `VPI_GK_NONE;
  end

  wire accept;
  wire [15:0] gvec;
  wire [15:0] win_vec;
  wire [4:0] win_pri;

  assign accept = irq_req_out & int_ack_in;
  assign gvec = (gkind_reg == `VPI_GK_RESET) ? `VPI_VEC_RESET :
                (gkind_reg == `VPI_GK_BREAK) ? `VPI_VEC_BREAK :
                (`VPI_VEC_FIRST - {11'h000, gidx_reg, 1'b0});
  assign win_vec = (gkind_next == `VPI_GK_RESET) ? `VPI_VEC_RESET :
                   (gkind_next == `VPI_GK_BREAK) ? `VPI_VEC_BREAK :
                   (`VPI_VEC_FIRST - {11'h000, win_idx, 1'b0});
  assign win_pri = (gkind_next == `VPI_GK_RESET) ? `VPI_PRI_RESET :
                   (gkind_next == `VPI_GK_BREAK) ? `VPI_PRI_BREAK :
                   (`VPI_PRI_FIRST + {1'b0, win_idx});

  // ------------------------------------------------------------
  // register bus decode
  // ------------------------------------------------------------
  wire do_write;
  wire [3:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire wr_req;
  wire wr_ena;
  wire wr_ctrl;
  wire wr_ok;
  wire do_read;
  reg [31:0] rd_data;
  reg rd_ok;

  assign wr_addr = aw_have_reg ? aw_addr_reg : s_axi_awaddr_in;
  assign wr_data = w_have_reg ? w_data_reg : s_axi_wdata_in;
  assign wr_strb = w_have_reg ? w_strb_reg : s_axi_wstrb_in;
  assign do_write = (aw_have_reg | (s_axi_awvalid_in & s_axi_awready_out))
                    & (w_have_reg | (s_axi_wvalid_in & s_axi_wready_out))
                    & ~s_axi_bvalid_out;
  assign wr_req = do_write & (wr_addr == `VPI_OFS_REQ);
  assign wr_ena = do_write & (wr_addr == `VPI_OFS_ENA);
  assign wr_ctrl = do_write & (wr_addr == `VPI_OFS_CTRL);
  assign wr_ok = (wr_addr == `VPI_OFS_REQ) | (wr_addr == `VPI_OFS_ENA) |
                 (wr_addr == `VPI_OFS_CTRL) | (wr_addr == `VPI_OFS_STAT);
  assign do_read = s_axi_arvalid_in & s_axi_arready_out;

  always @*
  begin
    rd_ok = 1'b1;
    case (s_axi_araddr_in)
      `VPI_OFS_REQ: rd_data = {16'h0000, break_pend_reg, req_reg};
      `VPI_OFS_ENA: rd_data = {17'h00000, ena_reg};
      `VPI_OFS_CTRL: rd_data = {22'h000000, sel_reg, pol_reg, idis_reg};
      `VPI_OFS_STAT: rd_data = {16'h0000, reset_pend_reg, 2'h0,
                                irq_priority_out, 7'h00, irq_req_out};
      default:
      begin
        rd_data = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // request bits, one per slot
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NSLOT; g = g + 1)
    begin : slot
      wire sw_clr;
      wire hw_clr;
      // writing 0 clears, writing 1 leaves the bit alone
      assign sw_clr = wr_req & wr_strb[g / 8] & ~wr_data[g];
      assign hw_clr = accept & (gkind_reg == `VPI_GK_MASK) &
                      (gidx_reg == g);
      always @(posedge ref_clk_in)
      begin
        if (!reset_n_in)
          req_reg[g] <= 1'b0;
        else if (src_set[g])
          req_reg[g] <= 1'b1; // set beats any clear
        else if (sw_clr | hw_clr)
          req_reg[g] <= 1'b0;
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // control state and core handshake
  // ------------------------------------------------------------
  always @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      ena_reg <= `VPI_ENA_RST;
      pol_reg <= `VPI_POL_RST;
      sel_reg <= `VPI_SEL_RST;
      idis_reg <= `VPI_IDIS_RST;
      break_pend_reg <= 1'b0;
      reset_pend_reg <= 1'b1;
      pin_prev_reg <= 5'h00;
      blank_prev_reg <= 1'b0;
      digit_prev_reg <= 1'b0;
      gkind_reg <= `VPI_GK_NONE;
      gidx_reg <= 4'h0;
      irq_req_out <= 1'b0;
      irq_priority_out <= 5'h00;
      irq_vector_out <= 16'h0000;
      push_state_out <= 1'b0;
      load_pc_out <= 1'b0;
      load_vector_out <= 16'h0000;
      stop_wait_done_out <= 1'b0;
    end
    else
    begin
      pin_prev_reg <= pin_eff;
      blank_prev_reg <= vacuum_display_blank_in;
      digit_prev_reg <= vacuum_display_digit_in;
      if (wr_ena)
      begin
        if (wr_strb[0])
          ena_reg[7:0] <= wr_data[7:0];
        if (wr_strb[1])
          ena_reg[14:8] <= wr_data[14:8];
      end
      if (wr_ctrl & wr_strb[0])
      begin
        pol_reg <= wr_data[`VPI_CTRL_POL_LO+4:`VPI_CTRL_POL_LO];
      end
      if (wr_ctrl & wr_strb[1])
        sel_reg <= wr_data[`VPI_CTRL_SEL_LO+3:`VPI_CTRL_SEL_LO];
      // hardware set on acceptance wins over a software clear
      if (accept)
        idis_reg <= 1'b1;
      else if (wr_ctrl & wr_strb[0])
        idis_reg <= wr_data[`VPI_CTRL_IDIS];
      if (break_instruction_in)
        break_pend_reg <= 1'b1;
      else if (accept & (gkind_reg == `VPI_GK_BREAK))
        break_pend_reg <= 1'b0;
      if (accept & (gkind_reg == `VPI_GK_RESET))
        reset_pend_reg <= 1'b0;
      // the offered grant's vector is captured into load_vector_out in the ack cycle so the core
      // always services exactly what it acknowledged
      gkind_reg <= gkind_next;
      gidx_reg <= win_idx;
      irq_req_out <= (gkind_next != `VPI_GK_NONE) & ~accept;
      irq_priority_out <= win_pri;
      irq_vector_out <= win_vec;
      push_state_out <= accept;
      load_pc_out <= push_state_out;
      if (accept)
        load_vector_out <= gvec;
      stop_wait_done_out <= stop_instruction_in & timer_unf_in[2];
    end
  end

  // ------------------------------------------------------------
  // axi4-lite handshakes
  // ------------------------------------------------------------
  always @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `VPI_RESP_OKAY;
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rresp_out <= `VPI_RESP_OKAY;
      s_axi_rdata_out <= 32'h00000000;
    end
    else
    begin
      if (s_axi_awvalid_in & s_axi_awready_out & ~do_write)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in & s_axi_wready_out & ~do_write)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_in;
        w_strb_reg <= s_axi_wstrb_in;
      end
      if (do_write)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_ok ? `VPI_RESP_OKAY : `VPI_RESP_SLVERR;
      end
      else if (s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
      // one write in flight: ready drops once a channel is taken
      s_axi_awready_out <= ~s_axi_bvalid_out & ~do_write & ~aw_have_reg &
                           ~(s_axi_awvalid_in & s_axi_awready_out);
      s_axi_wready_out <= ~s_axi_bvalid_out & ~do_write & ~w_have_reg &
                          ~(s_axi_wvalid_in & s_axi_wready_out);
      if (do_read)
      begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= rd_data;
        s_axi_rresp_out <= rd_ok ? `VPI_RESP_OKAY : `VPI_RESP_SLVERR;
      end
      else if (s_axi_rready_in)
        s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= ~s_axi_rvalid_out & ~do_read & ~s_axi_arready_out;
    end
  end

endmodule
